// ==== hw/pfo_pkg.sv ====
package pfo_pkg;

    // ****************************************
    // Register map (byte addresses)
    // ****************************************
    localparam logic [3:0] OFS_FAULT_A_CFG = 4'h0;  // fault_a_configuration
    localparam logic [3:0] OFS_FAULT_B_CFG = 4'h4;  // fault_b_configuration
    localparam logic [3:0] OFS_STATUS      = 4'h8;  // Flags, levels, hold state
    localparam logic [3:0] OFS_CTRL        = 4'hc;  // Irq enables, priority, port pin

    // ****************************************
    // Fault configuration fields
    // ****************************************
    localparam int         CFG_EN_LSB     = 0;        // Pair enables 3:0
    localparam int         CFG_MODE_BIT   = 7;        // 0 latched, 1 cycle-by-cycle
    localparam int         CFG_STATE_LSB  = 8;        // Pin states 15:8, H1 L1 H2 L2 ...
    localparam logic [15:0] CFG_WR_MASK   = 16'hff8f; // Bits 6:4 reserved, read zero
    localparam logic [15:0] CFG_RST       = 16'h0000;
    localparam logic        MODE_LATCHED  = 1'b0;

    // ****************************************
    // Control register fields
    // ****************************************
    localparam int          CTRL_IE_LSB   = 0;        // Irq enable A, B
    localparam int          CTRL_PRIO_LSB = 2;        // Priority A 4:2, B 7:5
    localparam int          PRIO_W        = 3;
    localparam int          CTRL_DIR_LSB  = 8;        // Pin direction A, B: 1 input
    localparam int          CTRL_POUT_LSB = 10;       // Port output bit A, B
    localparam logic [15:0] CTRL_WR_MASK  = 16'h0fff;
    localparam logic [15:0] CTRL_RST      = 16'h0300;

    // ****************************************
    // Status register fields
    // ****************************************
    localparam int ST_FLAG_LSB = 0;  // Irq flags A, B, write one to clear
    localparam int ST_LVL_LSB  = 2;  // Port input level A, B
    localparam int ST_ACT_LSB  = 4;  // Fault hold A, B

    // ****************************************
    // Bus constants
    // ****************************************
    localparam int         HTRANS_ACT_BIT = 1;     // NONSEQ or SEQ
    localparam logic [1:0] HRESP_OKAY     = 2'h0;

endpackage : pfo_pkg

// ==== hw/pfo_fault_override.sv ====
`timescale 1ns/1ps
module pfo_fault_override #(
    parameter int PAIRS = 4,   // Output pairs
    parameter int TMR_W = 16   // Time base width
) (
    // Clock and reset
    input  wire logic                CLOCK_I,
    input  wire logic                RST_N_I,
    // AHB-Lite slave
    input  wire logic                HSEL_I,
    input  wire logic [31:0]         HADDR_I,
    input  wire logic [1:0]          HTRANS_I,
    input  wire logic                HWRITE_I,
    input  wire logic [2:0]          HSIZE_I,
    input  wire logic [31:0]         HWDATA_I,
    input  wire logic                HREADY_I,
    output logic      [31:0]         HRDATA_O,
    output logic                     HREADYOUT_O,
    output logic      [1:0]          HRESP_O,
    // Fault pins, shared with port bits (oe low drives)
    input  wire logic                FAULT_INPUT_A_I,
    input  wire logic                FAULT_INPUT_B_I,
    output logic                     FAULT_PIN_A_O,
    output logic                     FAULT_PIN_A_OE_N_O,
    output logic                     FAULT_PIN_B_O,
    output logic                     FAULT_PIN_B_OE_N_O,
    // Time base and PWM generator
    input  wire logic [TMR_W-1:0]    PWM_TIMER_COUNT_I,
    input  wire logic [TMR_W-1:0]    PWM_PERIOD_VALUE_I,
    input  wire logic                TIMEBASE_ENABLE_I,
    input  wire logic                CENTER_ALIGNED_I,
    input  wire logic [PAIRS-1:0]    COMPLEMENTARY_I,
    input  wire logic [2*PAIRS-1:0]  PWM_NORMAL_I,
    input  wire logic                HIGH_SIDE_POLARITY_CFG_I,
    input  wire logic                LOW_SIDE_POLARITY_CFG_I,
    // Outputs
    output logic      [2*PAIRS-1:0]  PWM_PIN_O,
    output logic                     FAULT_A_IRQ_O,
    output logic                     FAULT_B_IRQ_O,
    output logic      [2:0]          FAULT_A_PRIO_O,
    output logic      [2:0]          FAULT_B_PRIO_O
);

    // ****************************************
    // Helpers
    // ****************************************

    // Spread pair enables onto both pins of each pair
    function automatic logic [2*PAIRS-1:0] pair_to_pins(input logic [PAIRS-1:0] en);
        logic [2*PAIRS-1:0] m;
        m = '0;
        for (int p = 0; p < PAIRS; p++) begin
            m[2*p]   = en[p];
            m[2*p+1] = en[p];
        end
        return m;
    endfunction : pair_to_pins

    // ****************************************
    // Declarations
    // ****************************************
    localparam int      CFG_EN_LSB = pfo_pkg::CFG_EN_LSB; // Pair enable field base
    logic [15:0]        cfg_reg [2];        // Index 0 input A, 1 input B
    logic [15:0]        ctrl_reg;           // Irq enables, priority, port pin
    logic [1:0]         flag_reg;           // Sticky irq flags
    logic [1:0]         act_reg;            // Fault hold per input
    logic [1:0]         meta_reg;           // Synchroniser first stage
    logic [1:0]         sync_reg;           // Synchroniser second stage
    logic [1:0]         prev_reg;           // Last synchronised assertion
    logic               wr_pend_reg;        // Write data phase pending
    logic [3:0]         wr_addr_reg;        // Captured write offset
    logic [2*PAIRS-1:0] forced_reg;         // Pins forced last cycle
    logic [2*PAIRS-1:0] logic_reg;          // Logical pin level last cycle

    logic [PAIRS-1:0]   en    [2];          // Pair enables per input
    logic [2*PAIRS-1:0] state [2];          // Fault pin states per input
    logic [1:0]         mode;               // Per input mode bit
    logic [1:0]         dir;                // Pin direction, 1 input
    logic [1:0]         pout;               // Port output bits
    logic [1:0]         lvl_raw;            // Level seen now
    logic [1:0]         lvl_sync;           // Level after synchroniser
    logic [1:0]         asrt_raw;           // Enabled and low now
    logic [1:0]         asrt_sync;          // Enabled and low, synchronised
    logic [1:0]         release_ok;         // Release condition met
    logic [1:0]         flag_clr;           // Software clear strobe
    logic               boundary;           // Period or half-period point
    logic               restore_ok;         // Boundary or time base off
    logic               addr_phase;         // Valid transfer address phase
    logic [3:0]         ofs;                // Word offset of address phase
    logic [31:0]        rd_mux;             // Read data of address phase
    logic [2*PAIRS-1:0] mask_a;             // Pins forced by A
    logic [2*PAIRS-1:0] mask_b;             // Pins forced by B
    logic [2*PAIRS-1:0] force_pins;         // Pins forced by any input
    logic [2*PAIRS-1:0] fault_st;           // Chosen fault state per pin
    logic [2*PAIRS-1:0] logic_next;         // Logical level per pin
    logic [2*PAIRS-1:0] pin_next;           // Physical level per pin
    logic [2*PAIRS-1:0] pol;                // Active-high per pin

    // ****************************************
    // Field decode
    // ****************************************

    // Shared port pin: output mode feeds the port bit to the fault logic
    always_comb begin
        for (int i = 0; i < 2; i++) begin
            en[i]    = cfg_reg[i][CFG_EN_LSB +: PAIRS];
            state[i] = cfg_reg[i][pfo_pkg::CFG_STATE_LSB +: 2*PAIRS];
            mode[i]  = cfg_reg[i][pfo_pkg::CFG_MODE_BIT];
            dir[i]   = ctrl_reg[pfo_pkg::CTRL_DIR_LSB + i];
            pout[i]  = ctrl_reg[pfo_pkg::CTRL_POUT_LSB + i];
            lvl_sync[i] = dir[i] ? sync_reg[i] : pout[i];
            // Low means fault; no enable means no effect at all
            asrt_raw[i]  = ~lvl_raw[i] & (|en[i]);
            asrt_sync[i] = ~lvl_sync[i] & (|en[i]);
            // Latched waits for the flag too; cycle-by-cycle only the level
            release_ok[i] = ~asrt_raw[i] & ~asrt_sync[i]
                          & ((mode[i] != pfo_pkg::MODE_LATCHED) | ~flag_reg[i]);
        end
    end

    assign lvl_raw[0] = dir[0] ? FAULT_INPUT_A_I : pout[0];
    assign lvl_raw[1] = dir[1] ? FAULT_INPUT_B_I : pout[1];

    // Edge-aligned: timer zero; center-aligned: zero or period
    assign boundary   = (PWM_TIMER_COUNT_I == '0)
                      | (CENTER_ALIGNED_I & (PWM_TIMER_COUNT_I == PWM_PERIOD_VALUE_I));
    assign restore_ok = boundary | ~TIMEBASE_ENABLE_I;

    // ****************************************
    // Fault input synchroniser
    // ****************************************

    // Two stages; only the second stage is looked at
    always_ff @(posedge CLOCK_I) begin
        if (!RST_N_I) begin
            meta_reg <= 2'h3;
            sync_reg <= 2'h3;
        end else begin
            meta_reg <= {FAULT_INPUT_B_I, FAULT_INPUT_A_I};
            sync_reg <= meta_reg;
        end
    end

    // ****************************************
    // Fault hold state
    // ****************************************

    // Entry on the raw level, exit only on a restore point
    always_ff @(posedge CLOCK_I) begin
        if (!RST_N_I) begin
            act_reg <= 2'h0;
        end else begin
            for (int i = 0; i < 2; i++) begin
                if (asrt_raw[i]) begin
                    act_reg[i] <= 1'b1;
                end else if (release_ok[i] && restore_ok) begin
                    act_reg[i] <= 1'b0;
                end
            end
        end
    end

    // ****************************************
    // Interrupt flags
    // ****************************************

    // New assertion sets; a set in the clearing cycle wins
    always_ff @(posedge CLOCK_I) begin
        if (!RST_N_I) begin
            prev_reg <= 2'h0;
            flag_reg <= 2'h0;
        end else begin
            prev_reg <= asrt_sync;
            for (int i = 0; i < 2; i++) begin
                if (asrt_sync[i] && !prev_reg[i]) begin
                    flag_reg[i] <= 1'b1;
                end else if (flag_clr[i]) begin
                    flag_reg[i] <= 1'b0;
                end
            end
        end
    end

    // Each input has its own request line and priority
    always_ff @(posedge CLOCK_I) begin
        if (!RST_N_I) begin
            FAULT_A_IRQ_O  <= 1'b0;
            FAULT_B_IRQ_O  <= 1'b0;
            FAULT_A_PRIO_O <= '0;
            FAULT_B_PRIO_O <= '0;
        end else begin
            FAULT_A_IRQ_O  <= flag_reg[0] & ctrl_reg[pfo_pkg::CTRL_IE_LSB];
            FAULT_B_IRQ_O  <= flag_reg[1] & ctrl_reg[pfo_pkg::CTRL_IE_LSB + 1];
            FAULT_A_PRIO_O <= ctrl_reg[pfo_pkg::CTRL_PRIO_LSB +: pfo_pkg::PRIO_W];
            FAULT_B_PRIO_O <= ctrl_reg[pfo_pkg::CTRL_PRIO_LSB + pfo_pkg::PRIO_W +: pfo_pkg::PRIO_W];
        end
    end

    // ****************************************
    // Output forcing
    // ****************************************

    // A wins over B pin by pin; fault beats duty and override results
    always_comb begin
        mask_a     = pair_to_pins(en[0]) & {2*PAIRS{act_reg[0] | asrt_raw[0]}};
        mask_b     = pair_to_pins(en[1]) & {2*PAIRS{act_reg[1] | asrt_raw[1]}};
        force_pins = mask_a | mask_b;
        fault_st   = (mask_a & state[0]) | (~mask_a & mask_b & state[1]);
        // Two active states on a complementary pair would short the leg
        for (int p = 0; p < PAIRS; p++) begin
            if (COMPLEMENTARY_I[p] && fault_st[2*p]) begin
                fault_st[2*p+1] = 1'b0;
            end
        end
        logic_next = (force_pins & fault_st) | (~force_pins & PWM_NORMAL_I);
        pol        = {PAIRS{LOW_SIDE_POLARITY_CFG_I, HIGH_SIDE_POLARITY_CFG_I}};
        pin_next   = ~(logic_next ^ pol);
    end

    // Pins come from flops, so a fault shows one edge after the input falls
    always_ff @(posedge CLOCK_I) begin
        if (!RST_N_I) begin
            PWM_PIN_O  <= '0;
            forced_reg <= '0;
            logic_reg  <= '0;
        end else begin
            PWM_PIN_O  <= pin_next;
            forced_reg <= force_pins;
            logic_reg  <= logic_next;
        end
    end

    // Port pin drives while its direction bit is clear
    always_ff @(posedge CLOCK_I) begin
        if (!RST_N_I) begin
            FAULT_PIN_A_O      <= 1'b0;
            FAULT_PIN_A_OE_N_O <= 1'b1;
            FAULT_PIN_B_O      <= 1'b0;
            FAULT_PIN_B_OE_N_O <= 1'b1;
        end else begin
            FAULT_PIN_A_O      <= pout[0];
            FAULT_PIN_A_OE_N_O <= dir[0];
            FAULT_PIN_B_O      <= pout[1];
            FAULT_PIN_B_OE_N_O <= dir[1];
        end
    end

    // ****************************************
    // AHB-Lite slave
    // ****************************************

    assign addr_phase = HSEL_I & HTRANS_I[pfo_pkg::HTRANS_ACT_BIT] & HREADY_I;
    assign ofs        = {HADDR_I[3:2], 2'h0};
    assign flag_clr   = (wr_pend_reg && wr_addr_reg == pfo_pkg::OFS_STATUS)
                      ? HWDATA_I[pfo_pkg::ST_FLAG_LSB +: 2] : 2'h0;

    // Read mux; unmapped offsets read as zero
    always_comb begin
        rd_mux = '0;
        if (HADDR_I[31:4] == '0) begin
            case (ofs)
                pfo_pkg::OFS_FAULT_A_CFG: rd_mux[15:0] = cfg_reg[0];
                pfo_pkg::OFS_FAULT_B_CFG: rd_mux[15:0] = cfg_reg[1];
                pfo_pkg::OFS_STATUS: begin
                    rd_mux[pfo_pkg::ST_FLAG_LSB +: 2] = flag_reg;
                    rd_mux[pfo_pkg::ST_LVL_LSB +: 2]  = lvl_sync;
                    rd_mux[pfo_pkg::ST_ACT_LSB +: 2]  = act_reg;
                end
                pfo_pkg::OFS_CTRL:        rd_mux[15:0] = ctrl_reg;
                default:                  rd_mux = '0;
            endcase
        end
    end

    // Zero wait states: read data captured at the address phase edge
    always_ff @(posedge CLOCK_I) begin
        if (!RST_N_I) begin
            HRDATA_O    <= '0;
            HREADYOUT_O <= 1'b1;
            HRESP_O     <= pfo_pkg::HRESP_OKAY;
            wr_pend_reg <= 1'b0;
            wr_addr_reg <= '0;
        end else begin
            HREADYOUT_O <= 1'b1;
            HRESP_O     <= pfo_pkg::HRESP_OKAY;
            wr_pend_reg <= addr_phase & HWRITE_I & (HADDR_I[31:4] == '0);
            wr_addr_reg <= ofs;
            if (addr_phase && !HWRITE_I) begin
                HRDATA_O <= rd_mux;
            end
        end
    end

    // Register writes land at the end of the data phase
    always_ff @(posedge CLOCK_I) begin
        if (!RST_N_I) begin
            cfg_reg[0] <= pfo_pkg::CFG_RST;
            cfg_reg[1] <= pfo_pkg::CFG_RST;
            ctrl_reg   <= pfo_pkg::CTRL_RST;
        end else if (wr_pend_reg) begin
            case (wr_addr_reg)
                pfo_pkg::OFS_FAULT_A_CFG: cfg_reg[0] <= HWDATA_I[15:0] & pfo_pkg::CFG_WR_MASK;
                pfo_pkg::OFS_FAULT_B_CFG: cfg_reg[1] <= HWDATA_I[15:0] & pfo_pkg::CFG_WR_MASK;
                pfo_pkg::OFS_CTRL:        ctrl_reg   <= HWDATA_I[15:0] & pfo_pkg::CTRL_WR_MASK;
                default:                  ctrl_reg   <= ctrl_reg;
            endcase
        end
    end

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge CLOCK_I); endclocking
    default disable iff (!RST_N_I);

    sequence s_a_held;
        act_reg[0] && !(release_ok[0] && restore_ok);
    endsequence

    sequence s_a_entry;
        asrt_raw[0] && en[0][0];
    endsequence

    property p_no_enable_no_flag;
        $rose(flag_reg[0]) |-> $past(|en[0]);
    endproperty
    a_no_enable_no_flag: assert property (p_no_enable_no_flag)
        else $error("flag A set with no pair enabled");

    property p_entry_pin;
        s_a_entry |=> PWM_PIN_O[0] == $past(~(state[0][0] ^ HIGH_SIDE_POLARITY_CFG_I));
    endproperty
    a_entry_pin: assert property (p_entry_pin)
        else $error("pin H1 not at fault A state after entry");

    property p_comp_guard;
        $past(COMPLEMENTARY_I[0]) && forced_reg[1:0] == 2'h3 |-> !(logic_reg[0] && logic_reg[1]);
    endproperty
    a_comp_guard: assert property (p_comp_guard)
        else $error("both pins of complementary pair active in fault");

    property p_held_stays;
        s_a_held |=> act_reg[0];
    endproperty
    a_held_stays: assert property (p_held_stays)
        else $error("fault A released without its conditions");

    property p_latched_low_holds;
        act_reg[0] && mode[0] == pfo_pkg::MODE_LATCHED && asrt_sync[0] |=> act_reg[0];
    endproperty
    a_latched_low_holds: assert property (p_latched_low_holds)
        else $error("latched fault A released while input low");

    property p_exit_on_boundary;
        $fell(act_reg[0]) && $past(TIMEBASE_ENABLE_I) |-> $past(boundary);
    endproperty
    a_exit_on_boundary: assert property (p_exit_on_boundary)
        else $error("fault A restored off a boundary");

    property p_tb_off_restore;
        act_reg[1] && release_ok[1] && !TIMEBASE_ENABLE_I |=> !act_reg[1];
    endproperty
    a_tb_off_restore: assert property (p_tb_off_restore)
        else $error("fault B not restored with time base off");

    property p_flag_sets;
        asrt_sync[0] && !prev_reg[0] |=> flag_reg[0] ##1 flag_reg[0] || $past(flag_clr[0]);
    endproperty
    a_flag_sets: assert property (p_flag_sets)
        else $error("flag A not set on assertion");

    property p_flag_sticky;
        flag_reg[1] && !flag_clr[1] |=> flag_reg[1];
    endproperty
    a_flag_sticky: assert property (p_flag_sticky)
        else $error("flag B dropped without clear");

    property p_a_over_b;
        act_reg[0] && en[0][0] && act_reg[1] && en[1][0] |=> logic_reg[0] == $past(state[0][0]);
    endproperty
    a_a_over_b: assert property (p_a_over_b)
        else $error("pair 1 not at fault A state while both active");

endmodule : pfo_fault_override

// ==== tb/pfo_fault_src.sv ====
`timescale 1ns/1ps
// ****************************************
// External fault source on pulled-up lines
// ****************************************
module pfo_fault_src (
    // Requests from the bench
    input  wire logic ask_a_i,
    input  wire logic ask_b_i,
    // Port drive from the device, oe low drives
    input  wire logic drv_a_i,
    input  wire logic oe_a_n_i,
    input  wire logic drv_b_i,
    input  wire logic oe_b_n_i,
    // Resolved line levels
    output logic      line_a_o,
    output logic      line_b_o
);
    // Open drain with pull-up; a driven port pin masks the outside world
    assign line_a_o = !oe_a_n_i ? drv_a_i : !ask_a_i;
    assign line_b_o = !oe_b_n_i ? drv_b_i : !ask_b_i;
endmodule : pfo_fault_src

// ==== tb/testbench.sv ====
`timescale 1ns/1ps
module testbench;
    // ****************************************
    // Signals
    // ****************************************
    logic        clk, rst_n, hsel, hwrite, ask_a, ask_b, tben, ctr, la, lb;
    logic        hrdy, pa, pa_n, pb, pb_n, irq_a, irq_b, high_side_polarity_cfg, low_side_polarity_cfg;
    logic [1:0]  htrans, hresp;
    logic [2:0]  prio_a, prio_b;
    logic [3:0]  comp;
    logic [7:0]  norm, pins;
    logic [15:0] tmr, per;
    logic [31:0] haddr, hwdata, hrdata, q;
    int          err_total, checks_done;
    localparam logic [31:0] CA = {28'h0, pfo_pkg::OFS_FAULT_A_CFG};
    localparam logic [31:0] CB = {28'h0, pfo_pkg::OFS_FAULT_B_CFG};
    localparam logic [31:0] ST = {28'h0, pfo_pkg::OFS_STATUS};
    localparam logic [31:0] CT = {28'h0, pfo_pkg::OFS_CTRL};

    // ****************************************
    // Device and fault source
    // ****************************************
    pfo_fault_override dut (.CLOCK_I(clk), .RST_N_I(rst_n), .HSEL_I(hsel), .HADDR_I(haddr),
        .HTRANS_I(htrans), .HWRITE_I(hwrite), .HSIZE_I(3'h2), .HWDATA_I(hwdata),
        .HREADY_I(hrdy), .HRDATA_O(hrdata), .HREADYOUT_O(hrdy), .HRESP_O(hresp),
        .FAULT_INPUT_A_I(la), .FAULT_INPUT_B_I(lb), .FAULT_PIN_A_O(pa),
        .FAULT_PIN_A_OE_N_O(pa_n), .FAULT_PIN_B_O(pb), .FAULT_PIN_B_OE_N_O(pb_n),
        .PWM_TIMER_COUNT_I(tmr), .PWM_PERIOD_VALUE_I(per), .TIMEBASE_ENABLE_I(tben),
        .CENTER_ALIGNED_I(ctr), .COMPLEMENTARY_I(comp), .PWM_NORMAL_I(norm),
        .HIGH_SIDE_POLARITY_CFG_I(high_side_polarity_cfg), .LOW_SIDE_POLARITY_CFG_I(low_side_polarity_cfg), .PWM_PIN_O(pins),
        .FAULT_A_IRQ_O(irq_a), .FAULT_B_IRQ_O(irq_b), .FAULT_A_PRIO_O(prio_a),
        .FAULT_B_PRIO_O(prio_b));
    pfo_fault_src src (.ask_a_i(ask_a), .ask_b_i(ask_b), .drv_a_i(pa), .oe_a_n_i(pa_n),
        .drv_b_i(pb), .oe_b_n_i(pb_n), .line_a_o(la), .line_b_o(lb));

    // Free running clock, 8 ns
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // ****************************************
    // Tasks
    // ****************************************
    task automatic print_verdict;
        $display("checks_done=%0d err_total=%0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : print_verdict

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // Bounded wait for hready; the slave never stalls, but a hang must end
    task automatic wait_rdy;
        int n;
        n = 0;
        @(posedge clk);
        while (hrdy !== 1'b1 && n < 50) begin
            @(posedge clk);
            n++;
        end
        if (n >= 50) begin
            err_total++;
            $display("[ERR] %0t bus wait expired", $time);
            print_verdict();
        end
    endtask : wait_rdy

    // One single word transfer; entered and left just after a rising edge
    task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
        htrans <= 2'h2;
        hwrite <= wr;
        haddr  <= a;
        wait_rdy();
        htrans <= 2'h0;
        hwdata <= d;
        wait_rdy();
        q = hrdata;
    endtask : bus

    task automatic rd(input logic [31:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        chk(q, exp);
    endtask : rd

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask : cyc

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        {rst_n, hsel, hwrite, ask_a, ask_b, ctr, htrans, comp} = '0;
        {haddr, hwdata, err_total, checks_done} = '0;
        tben = 1'b1;
        high_side_polarity_cfg = 1'b1;
        low_side_polarity_cfg = 1'b0;
        norm = 8'h50;   // Pairs 3 and 4 high side active: physical 8'hfa
        tmr  = 16'h0005;
        per  = 16'h0040;
        cyc(20);
        rst_n <= 1'b1;
        hsel  <= 1'b1;
        cyc(1);
        rd(CA, 32'h0);
        rd(CT, 32'h0300);
        rd(32'h10, 32'h0);
        bus(1'b1, CB, 32'hffffffff);
        rd(CB, 32'h0000ff8f);
        // No pair enables: no forcing, no flag, level still visible
        bus(1'b1, CB, 32'hff80);
        ask_b <= 1'b1;
        cyc(6);
        chk(pins, 8'hfa);
        rd(ST, 32'h4);
        ask_b <= 1'b0;
        // Latched A driven by its own port pin, irq enabled, priority 5
        bus(1'b1, CA, 32'h0101);
        bus(1'b1, CT, 32'h0215);
        cyc(6);
        chk(pins, 8'hfb);
        chk({pa, pa_n, pb, pb_n}, 32'h1);
        chk({irq_a, prio_a}, 4'hd);
        rd(ST, 32'h19);
        bus(1'b1, ST, 32'h1);
        cyc(4);
        chk(pins, 8'hfb);
        bus(1'b1, CT, 32'h0300);
        cyc(6);
        chk(pins, 8'hfb);
        tmr <= 16'h0;
        cyc(3);
        chk(pins, 8'hfa);
        // A over B, centre aligned, B cycle-by-cycle
        bus(1'b1, CA, 32'h0201);
        bus(1'b1, CB, 32'h0181);
        ctr   <= 1'b1;
        tmr   <= 16'h0005;
        ask_a <= 1'b1;
        ask_b <= 1'b1;
        cyc(6);
        chk(pins, 8'hf8);
        // Irq enable B with priority 7; flag B is already set
        bus(1'b1, CT, 32'h03e2);
        cyc(2);
        chk({irq_b, prio_b, hresp}, 32'h3c);
        ask_a <= 1'b0;
        tmr   <= 16'h0;
        cyc(6);
        chk(pins, 8'hf8);
        tmr <= 16'h0005;
        bus(1'b1, ST, 32'h3);
        cyc(4);
        chk(pins, 8'hf8);
        tmr <= per;
        cyc(3);
        chk(pins, 8'hfb);
        // Off a boundary, so only the stopped time base can restore
        tben  <= 1'b0;
        tmr   <= 16'h0005;
        ask_b <= 1'b0;
        cyc(6);
        chk(pins, 8'hfa);
        // Complementary pair with both states active: high side wins
        tben <= 1'b1;
        comp <= 4'h1;
        bus(1'b1, CA, 32'h0301);
        ask_a <= 1'b1;
        cyc(4);
        chk(pins, 8'hfb);
        // Swap both side polarities: every pin level inverts
        high_side_polarity_cfg <= 1'b0;
        low_side_polarity_cfg <= 1'b1;
        cyc(3);
        chk(pins, 8'h04);
        print_verdict();
    end
endmodule : testbench
